/* design/aomsel_top.sv */
// auxiliary output mode selector with its stimulus fifo and avalon-mm register slave
// assumes mclk is the bit clock, inputs synchronous to mclk, master holds requests under waitrequest
//
// Function
// - divider mode accepts integer factors 2..128 and emits clock divided by factor
// - odd factor n: high (n+1)/2 bit periods, then low (n-1)/2
// - even factor n: high n/2 bit periods, then low n/2
// - aux output always driven, no enable; divider mode carries clock fraction
// - exactly one of four modes active: divider, dual, serializer, tap shift
// - dual mode: main and aux each take their own pattern source
// - dual mode: each stimulus block supplies content for both outputs
// - serializer mode: aux stops the sub-rate clock, carries second data stream
// - serializer mode: one pattern split automatically between main and aux
// - serializer mode: interleaving both streams reproduces the pattern exactly
// - serializer mode forced when accessory attached and enabled
// - manual mode selection locked while accessory attached
// - tap shift mode: aux is main stream displaced by one bit period
// - tap offset only -1 (aux leads) or +1 (aux lags)
//
// The implementer's own choices: the register offsets and the Avalon-MM register port.
`default_nettype none

module aomsel_fifo #(
    parameter int WIDTH = 2,
    parameter int DEPTH = 16
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);
    localparam logic [AW:0] FULL = (AW + 1)'(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    logic push;
    logic pop;

    assign in_ready = (count != FULL);
    assign out_valid = (count != '0);
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign out_data = mem[rd_ptr];

    // storage needs no reset; only pointers and count are control state
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            wr_ptr <= '0;
        end else if (push) begin
            wr_ptr <= (wr_ptr == LAST) ? '0 : wr_ptr + 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            rd_ptr <= '0;
        end else if (pop) begin
            rd_ptr <= (rd_ptr == LAST) ? '0 : rd_ptr + 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            count <= '0;
        end else if (push && !pop) begin
            count <= count + 1'b1;
        end else if (pop && !push) begin
            count <= count - 1'b1;
        end
    end
endmodule // aomsel_fifo

module aomsel_top #(
    parameter int FIFO_DEPTH = aomsel_pkg::FIFO_DEPTH
) (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic pat_valid,
    input wire aomsel_pkg::aomsel_word_s pat_word,
    output logic pat_ready,
    input wire logic ser_attached,
    output logic main_out,
    output logic aux_out
);
    aomsel_pkg::aomsel_mode_e manual_mode;
    aomsel_pkg::aomsel_mode_e eff_mode;
    aomsel_pkg::aomsel_word_s fifo_q;
    logic tap_pre;
    logic ser_en;
    logic run;
    logic underrun;
    logic [7:0] div_reg;
    logic [7:0] div_act;
    logic [7:0] div_cnt;
    logic [8:0] div_half;
    logic div_clk;
    logic bus_ack;
    logic wr_take;
    logic lane0;
    logic fifo_valid;
    logic pop;
    logic w_main;
    logic w_aux;
    logic ser_phase;
    logic even_bit;
    logic prev_bit;
    logic [7:0] next_div;

    aomsel_fifo #(
        .WIDTH($bits(aomsel_pkg::aomsel_word_s)),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk(mclk),
        .reset_n(reset_n),
        .in_valid(pat_valid),
        .in_ready(pat_ready),
        .in_data(pat_word),
        .out_valid(fifo_valid),
        .out_ready(run),
        .out_data(fifo_q)
    );

    // bus: one wait cycle, answer at the second edge of a request
    assign avs_waitrequest = (avs_read || avs_write) && !bus_ack;
    assign wr_take = avs_write && bus_ack;
    assign lane0 = avs_byteenable[0];

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            bus_ack <= 1'b0;
        end else begin
            bus_ack <= (avs_read || avs_write) && !bus_ack;
        end
    end

    // read data settles at the edge that drops waitrequest and then stands
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            avs_readdata <= 32'h0;
        end else if (avs_read && !bus_ack) begin
            case (avs_address)
                aomsel_pkg::OFS_CTRL: avs_readdata <= {27'h0, run, ser_en, tap_pre, manual_mode};
                aomsel_pkg::OFS_DIV: avs_readdata <= {24'h0, div_reg};
                aomsel_pkg::OFS_STATUS: avs_readdata <= {28'h0, underrun, ser_attached, eff_mode};
                default: avs_readdata <= 32'h0;
            endcase
        end
    end

    always_comb begin
        next_div = avs_writedata[7:0];
        if (avs_writedata[7:0] < aomsel_pkg::DIV_MIN) begin
            next_div = aomsel_pkg::DIV_MIN;
        end else if (avs_writedata[7:0] > aomsel_pkg::DIV_MAX) begin
            next_div = aomsel_pkg::DIV_MAX;
        end
    end

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            manual_mode <= aomsel_pkg::AOMSEL_DIVIDER;
        end else if (wr_take && lane0 && avs_address == aomsel_pkg::OFS_CTRL && !ser_attached) begin
            manual_mode <= aomsel_pkg::aomsel_mode_e'(avs_writedata[aomsel_pkg::CTRL_MODE_LSB +: 2]);
        end
    end

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            tap_pre <= aomsel_pkg::TAP_PRE_RESET;
            ser_en <= aomsel_pkg::SER_EN_RESET;
            run <= aomsel_pkg::RUN_RESET;
        end else if (wr_take && lane0 && avs_address == aomsel_pkg::OFS_CTRL) begin
            tap_pre <= avs_writedata[aomsel_pkg::CTRL_TAP_PRE];
            ser_en <= avs_writedata[aomsel_pkg::CTRL_SER_EN];
            run <= avs_writedata[aomsel_pkg::CTRL_RUN];
        end
    end

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            div_reg <= aomsel_pkg::DIV_RESET;
        end else if (wr_take && lane0 && avs_address == aomsel_pkg::OFS_DIV) begin
            div_reg <= next_div;
        end
    end

    // a missing stimulus bit sends zero; the set wins over a clear
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            underrun <= 1'b0;
        end else if (run && !fifo_valid) begin
            underrun <= 1'b1;
        end else if (wr_take && lane0 && avs_address == aomsel_pkg::OFS_STATUS
                     && avs_writedata[aomsel_pkg::ST_UNDERRUN]) begin
            underrun <= 1'b0;
        end
    end

    // accessory overrides the manual choice when attached with ser_en set
    assign eff_mode = (ser_attached && ser_en) ? aomsel_pkg::AOMSEL_SERIAL : manual_mode;

    // divider: new factor taken only at a period boundary, so no runt pulses
    assign div_half = ({1'b0, div_act} + 9'h001) >> 1;
    assign div_clk = ({1'b0, div_cnt} < div_half);

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            div_cnt <= 8'h00;
            div_act <= aomsel_pkg::DIV_RESET;
        end else if (div_cnt == div_act - 8'h01) begin
            div_cnt <= 8'h00;
            div_act <= div_reg;
        end else begin
            div_cnt <= div_cnt + 8'h01;
        end
    end

    assign pop = run && fifo_valid;
    assign w_main = pop ? fifo_q.main_bit : 1'b0;
    assign w_aux = pop ? fifo_q.aux_bit : 1'b0;

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            ser_phase <= 1'b0;
        end else if (eff_mode != aomsel_pkg::AOMSEL_SERIAL) begin
            ser_phase <= 1'b0;
        end else if (run) begin
            ser_phase <= !ser_phase;
        end
    end

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            even_bit <= 1'b0;
            prev_bit <= 1'b0;
        end else if (run) begin
            if (!ser_phase) begin
                even_bit <= w_main;
            end
            prev_bit <= w_main;
        end
    end

    // outputs always driven; only the stimulus stalls when run is low
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            main_out <= 1'b0;
            aux_out <= 1'b0;
        end else begin
            case (eff_mode)
                aomsel_pkg::AOMSEL_DIVIDER: begin
                    aux_out <= div_clk;
                    if (run) begin
                        main_out <= w_main;
                    end
                end
                aomsel_pkg::AOMSEL_DUAL: begin
                    if (run) begin
                        main_out <= w_main;
                        aux_out <= w_aux;
                    end
                end
                aomsel_pkg::AOMSEL_SERIAL: begin
                    if (run && ser_phase) begin
                        main_out <= even_bit;
                        aux_out <= w_main;
                    end
                end
                aomsel_pkg::AOMSEL_TAP: begin
                    if (run) begin
                        main_out <= tap_pre ? prev_bit : w_main;
                        aux_out <= tap_pre ? w_main : prev_bit;
                    end
                end
                default: begin
                    aux_out <= div_clk;
                end
            endcase
        end
    end

    logic tap_post_on;
    logic tap_pre_on;
    assign tap_post_on = (eff_mode == aomsel_pkg::AOMSEL_TAP) && !tap_pre && run;
    assign tap_pre_on = (eff_mode == aomsel_pkg::AOMSEL_TAP) && tap_pre && run;

    chk_div_range: assert property (@(posedge mclk) disable iff (!reset_n)
        div_act >= aomsel_pkg::DIV_MIN && div_act <= aomsel_pkg::DIV_MAX)
        else $error("divide factor out of range");

    chk_div_high_start: assert property (@(posedge mclk) disable iff (!reset_n)
        (eff_mode == aomsel_pkg::AOMSEL_DIVIDER && $stable(eff_mode) && div_cnt == 8'h00)
        |=> aux_out)
        else $error("divided clock not high at period start");

    chk_div_low_half: assert property (@(posedge mclk) disable iff (!reset_n)
        (eff_mode == aomsel_pkg::AOMSEL_DIVIDER && {1'b0, div_cnt} == div_half)
        |=> !aux_out)
        else $error("divided clock not low after high half");

    chk_div_last_high: assert property (@(posedge mclk) disable iff (!reset_n)
        (eff_mode == aomsel_pkg::AOMSEL_DIVIDER && {1'b0, div_cnt} == div_half - 9'h001)
        |=> aux_out)
        else $error("high half of divided clock too short");

    chk_auto_serial: assert property (@(posedge mclk) disable iff (!reset_n)
        (ser_attached && ser_en) |-> eff_mode == aomsel_pkg::AOMSEL_SERIAL)
        else $error("serializer mode not forced by accessory");

    chk_manual_lock: assert property (@(posedge mclk) disable iff (!reset_n)
        (ser_attached && wr_take && avs_address == aomsel_pkg::OFS_CTRL) |=> $stable(manual_mode))
        else $error("manual mode changed while accessory attached");

    chk_dual_aux: assert property (@(posedge mclk) disable iff (!reset_n)
        (eff_mode == aomsel_pkg::AOMSEL_DUAL && run) |=> aux_out == $past(w_aux))
        else $error("second channel bit lost");

    chk_ser_hold: assert property (@(posedge mclk) disable iff (!reset_n)
        (eff_mode == aomsel_pkg::AOMSEL_SERIAL && !ser_phase) |=> $stable(main_out) && $stable(aux_out))
        else $error("serializer outputs not at half rate");

    chk_ser_pair: assert property (@(posedge mclk) disable iff (!reset_n)
        (eff_mode == aomsel_pkg::AOMSEL_SERIAL && run && !ser_phase) ##1
        (eff_mode == aomsel_pkg::AOMSEL_SERIAL && run)
        |=> main_out == $past(w_main, 2) && aux_out == $past(w_main))
        else $error("serializer pair does not rebuild pattern");

    chk_tap_post: assert property (@(posedge mclk) disable iff (!reset_n)
        tap_post_on ##1 tap_post_on |=> aux_out == $past(main_out))
        else $error("postcursor stream not one bit late");

    chk_tap_pre: assert property (@(posedge mclk) disable iff (!reset_n)
        tap_pre_on ##1 tap_pre_on |=> main_out == $past(aux_out))
        else $error("precursor stream not one bit early");

    chk_bus_wait: assert property (@(posedge mclk) disable iff (!reset_n)
        (avs_read || avs_write) && !bus_ack |=> !avs_waitrequest)
        else $error("waitrequest held more than one cycle");

    cov_divider: cover property (@(posedge mclk) disable iff (!reset_n)
        eff_mode == aomsel_pkg::AOMSEL_DIVIDER && div_act == 8'h03 && $rose(aux_out));
    cov_dual: cover property (@(posedge mclk) disable iff (!reset_n)
        eff_mode == aomsel_pkg::AOMSEL_DUAL && pop);
    cov_serial: cover property (@(posedge mclk) disable iff (!reset_n)
        ser_attached && ser_en && run && ser_phase);
    cov_tap: cover property (@(posedge mclk) disable iff (!reset_n)
        tap_pre_on ##1 tap_pre_on);
    cov_fifo_full: cover property (@(posedge mclk) disable iff (!reset_n)
        pat_valid && !pat_ready);
endmodule // aomsel_top

`default_nettype wire

/* include/aomsel_pkg.sv */
// package for the auxiliary output mode selector: offsets, fields, reset values, modes
// assumes an avalon-mm slave with byte addresses and one bit period per mclk cycle
`default_nettype none

package aomsel_pkg;

    // register byte offsets
    localparam logic [3:0] OFS_CTRL = 4'h0;
    localparam logic [3:0] OFS_DIV = 4'h4;
    localparam logic [3:0] OFS_STATUS = 4'h8;

    // control field positions
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_TAP_PRE = 2;
    localparam int CTRL_SER_EN = 3;
    localparam int CTRL_RUN = 4;

    // status field positions
    localparam int ST_MODE_LSB = 0;
    localparam int ST_ATTACHED = 2;
    localparam int ST_UNDERRUN = 3;

    // divide factor limits and reset values
    localparam logic [7:0] DIV_MIN = 8'h02;
    localparam logic [7:0] DIV_MAX = 8'h80;
    localparam logic [7:0] DIV_RESET = 8'h02;
    localparam logic RUN_RESET = 1'b0;
    localparam logic TAP_PRE_RESET = 1'b0;
    localparam logic SER_EN_RESET = 1'b0;

    localparam int FIFO_DEPTH = 16;

    typedef enum logic [1:0] {
        AOMSEL_DIVIDER,
        AOMSEL_DUAL,
        AOMSEL_SERIAL,
        AOMSEL_TAP
    } aomsel_mode_e;

    // one bit period of stimulus: main channel bit and second channel bit
    typedef struct packed {
        logic main_bit;
        logic aux_bit;
    } aomsel_word_s;

endpackage

`default_nettype wire

/* tb/aomsel_sink.sv */
// far side model: passive resistor network that adds the main and auxiliary lines
// assumes both inputs are the block's registered outputs, always driven
`default_nettype none

module aomsel_sink (
    input wire logic main_in,
    input wire logic aux_in,
    output logic [1:0] level
);
    timeunit 1ns;
    timeprecision 1ps;

    // no clock and no memory, so a wrong bit on either line shows up at once
    assign level = {1'b0, main_in} + {1'b0, aux_in};

endmodule // aomsel_sink

`default_nettype wire

/* tb/aomsel_test.sv */
// self-checking bench: avalon register tasks, stimulus pushes and captured output streams
// assumes a 16-word stimulus fifo and a slave that answers under waitrequest
`default_nettype none

module aomsel_test;
    timeunit 1ns;
    timeprecision 1ps;

    localparam logic [15:0] P_M = 16'h8f3b;
    localparam logic [15:0] P_A = 16'h5ac6;
    localparam int NT[6] = '{2, 3, 4, 5, 127, 128};

    logic mclk = 1'b0;
    logic reset_n = 1'b0;
    logic [3:0] avs_address = 4'h0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [3:0] avs_byteenable = 4'h0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic pat_valid = 1'b0;
    aomsel_pkg::aomsel_word_s pat_word = 2'h0;
    logic pat_ready;
    logic ser_attached = 1'b0;
    logic main_out;
    logic aux_out;
    logic [1:0] level;
    logic cap_on = 1'b0;
    logic cm[$];
    logic ca[$];
    logic [1:0] cl[$];
    logic [31:0] rd;
    int bad_count = 0;
    int cmp_count = 0;
    int hi;
    int lo;
    int s;

    always #2.5 mclk = ~mclk;

    aomsel_top i_dut (.mclk(mclk), .reset_n(reset_n), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .pat_valid(pat_valid),
        .pat_word(pat_word), .pat_ready(pat_ready), .ser_attached(ser_attached), .main_out(main_out),
        .aux_out(aux_out));

    aomsel_sink i_sink (.main_in(main_out), .aux_in(aux_out), .level(level));

    // one sample per bit period, taken mid-cycle where the outputs are settled
    always @(negedge mclk) begin
        if (cap_on) begin
            cm.push_back(main_out);
            ca.push_back(aux_out);
            cl.push_back(level);
        end
    end

    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic cmp_reg(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected register at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic cmp_bit(input logic got, input logic exp);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected bit at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic cmp_cnt(input int got, input int exp);
        cmp_count++;
        if (got != exp) begin
            bad_count++;
            $display("unexpected count at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // waitrequest and read data are taken at the rising edge itself, before that edge's own updates;
    // no cycle limit here: only the watchdog ends a wait that never finishes
    task automatic bus(input logic wr, input logic [3:0] adr, input logic [31:0] wd, input logic [3:0] be);
        logic w;
        avs_address <= adr;
        avs_writedata <= wd;
        avs_byteenable <= be;
        avs_write <= wr;
        avs_read <= ~wr;
        do begin
            @(posedge mclk);
            w = avs_waitrequest;
            rd = avs_readdata;
        end while (w !== 1'b0);
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        @(posedge mclk);
    endtask

    // the word is held until the edge at which ready is seen high
    task automatic push(input logic m, input logic a);
        logic w;
        pat_valid <= 1'b1;
        pat_word <= {m, a};
        do begin
            @(posedge mclk);
            w = pat_ready;
        end while (w !== 1'b1);
        pat_valid <= 1'b0;
        @(posedge mclk);
    endtask

    // counts bit periods for which aux_out keeps level v
    task automatic run_len(input logic v, output int c);
        c = 0;
        while (aux_out === v && c < 300) begin
            c++;
            @(negedge mclk);
        end
    endtask

    task automatic meas(output int h, output int l);
        int d;
        @(negedge mclk);
        run_len(1'b1, d);
        run_len(1'b0, d);
        run_len(1'b1, h);
        run_len(1'b0, l);
    endtask

    // fills the fifo with run off, then runs and captures; s marks the first bit of the pattern
    task automatic run_mode(input logic [7:0] ctrl, input logic key);
        bus(1'b1, aomsel_pkg::OFS_CTRL, {24'h0, ctrl}, 4'hf);
        for (int k = 0; k < 16; k++) push(P_M[k], P_A[k]);
        pat_valid <= 1'b1;
        @(negedge mclk);
        cmp_bit(pat_ready, 1'b0);
        @(posedge mclk);
        pat_valid <= 1'b0;
        cm.delete();
        ca.delete();
        cl.delete();
        cap_on = 1'b1;
        bus(1'b1, aomsel_pkg::OFS_CTRL, {24'h0, ctrl | 8'h10}, 4'hf);
        repeat (40) @(posedge mclk);
        cap_on = 1'b0;
        bus(1'b1, aomsel_pkg::OFS_CTRL, {24'h0, ctrl}, 4'hf);
        s = 0;
        while (s < cm.size() - 20 && (key ? ca[s] : cm[s]) !== 1'b1) s++;
    endtask

    initial begin
        repeat (20) @(posedge mclk);
        reset_n <= 1'b1;
        @(posedge mclk);
        bus(1'b0, aomsel_pkg::OFS_CTRL, 32'h0, 4'hf);
        cmp_reg(rd, 32'h0);
        bus(1'b0, aomsel_pkg::OFS_DIV, 32'h0, 4'hf);
        cmp_reg(rd, 32'h2);
        bus(1'b0, 4'hc, 32'h0, 4'hf);
        cmp_reg(rd, 32'h0);
        bus(1'b1, aomsel_pkg::OFS_DIV, 32'h1, 4'hf);
        bus(1'b0, aomsel_pkg::OFS_DIV, 32'h0, 4'hf);
        cmp_reg(rd, 32'h2);
        bus(1'b1, aomsel_pkg::OFS_DIV, 32'hc8, 4'hf);
        bus(1'b1, aomsel_pkg::OFS_DIV, 32'h5, 4'h0);
        bus(1'b0, aomsel_pkg::OFS_DIV, 32'h0, 4'hf);
        cmp_reg(rd, 32'h80);
        // the first period after a new factor may still carry the old one, so measure twice
        for (int i = 0; i < 6; i++) begin
            bus(1'b1, aomsel_pkg::OFS_DIV, NT[i], 4'hf);
            meas(hi, lo);
            meas(hi, lo);
            cmp_cnt(hi, (NT[i] + 1) / 2);
            cmp_cnt(lo, NT[i] / 2);
        end
        run_mode(8'h01, 1'b0);
        for (int k = 0; k < 16; k++) begin
            cmp_bit(cm[s + k], P_M[k]);
            cmp_bit(ca[s + k], P_A[k]);
        end
        bus(1'b0, aomsel_pkg::OFS_STATUS, 32'h0, 4'hf);
        cmp_reg(rd, 32'h9);
        bus(1'b1, aomsel_pkg::OFS_STATUS, 32'h8, 4'hf);
        ser_attached <= 1'b1;
        bus(1'b1, aomsel_pkg::OFS_CTRL, 32'h0b, 4'hf);
        bus(1'b0, aomsel_pkg::OFS_CTRL, 32'h0, 4'hf);
        cmp_reg(rd, 32'h09);
        bus(1'b0, aomsel_pkg::OFS_STATUS, 32'h0, 4'hf);
        cmp_reg(rd, 32'h6);
        run_mode(8'h09, 1'b0);
        for (int j = 0; j < 16; j += 2) begin
            cmp_bit(cm[s + j], P_M[j]);
            cmp_bit(cm[s + j + 1], P_M[j]);
            cmp_bit(ca[s + j], P_M[j + 1]);
            cmp_bit(ca[s + j + 1], P_M[j + 1]);
        end
        ser_attached <= 1'b0;
        run_mode(8'h03, 1'b0);
        for (int k = 1; k < 16; k++) begin
            cmp_bit(cm[s + k], P_M[k]);
            cmp_reg({30'h0, cl[s + k]}, {31'h0, P_M[k]} + {31'h0, P_M[k - 1]});
        end
        run_mode(8'h07, 1'b1);
        for (int k = 1; k < 16; k++) begin
            cmp_bit(ca[s + k], P_M[k]);
            cmp_bit(cm[s + k], P_M[k - 1]);
        end
        end_sim();
    end

    // the whole sequence needs under two thousand cycles; this leaves a wide margin
    initial begin
        repeat (30000) @(posedge mclk);
        bad_count++;
        end_sim();
    end

endmodule // aomsel_test

`default_nettype wire
